// [verilog/dual_nco_align_power_protect.sv]
// per-dual route swap, oscillator alignment, power protection and event flags
// Overview of operation
// - swap bit sends in-phase result to Q
// - swap applied at datapath output end
// - alignment logic and registers exist per dual
// - mode 01 aligns to SYSREF edge
// - mode 10 aligns on data key
// - armed SYSREF mode aligns next rising edge
// - subclass 0 aligns on internal clock
// - pass or fail flag after attempt
// - 16-bit I/Q keys compared at input
// - key seen sets key match flag
// - alignment tripped event per dual
// - power from seven msbs squared sum
// - average over two power nine-plus-window pairs
// - trip when average exceeds 13-bit level
// - detection active only while monitor on
// - readback holds peak after crossing
// - detector taps input by shorter path
// - over-power trip event per dual
// - ramp start by protect or rotation, gain on
// - trip drives protect pin when enabled
`timescale 1ns/1ps
`default_nettype none
module dual_nco_align_power_protect (
	// clock, reset, enable
	input  wire logic             SYS_CLK,
	input  wire logic             RST,
	input  wire logic             CLK_EN,
	// register port
	input  wire logic             REG_WR,
	input  wire logic             REG_RD,
	input  wire logic [11:0]      REG_ADDR,
	input  wire logic [7:0]       REG_WDATA,
	output logic      [7:0]       REG_RDATA,
	// alignment events
	input  wire logic             SYSREF,
	input  wire logic             SUBCLASS1,
	input  wire logic             LMFC_ALIGN_REQ,
	input  wire logic             LMFC_ROTATE,
	input  wire logic [1:0]       NCO_PHASE_ZERO,
	output logic      [1:0]       NCO_CLEAR,
	// samples at converter input and datapath results
	input  wire logic [1:0][15:0] DIN_I,
	input  wire logic [1:0][15:0] DIN_Q,
	input  wire logic [1:0][15:0] DP_I,
	input  wire logic [1:0][15:0] DP_Q,
	output logic      [1:0][15:0] DAC_I,
	output logic      [1:0][15:0] DAC_Q,
	// protection
	input  wire logic [1:0]       TX_PROTECT,
	output logic      [1:0]       OVERPOWER_TRIP,
	output logic      [1:0]       PROTECT_OUT,
	output logic      [1:0]       RAMP_START,
	output logic                  IRQ
);
	logic [1:0]                        page;
	logic                              sysref_s1;
	logic                              sysref_s2;
	logic                              sysref_s3;
	logic                              sysref_rise;
	logic [1:0][1:0]                   mode;
	logic [1:0]                        arm;
	logic [1:0]                        match_flag;
	logic [1:0]                        pass_flag;
	logic [1:0]                        fail_flag;
	logic [1:0][15:0]                  key_i;
	logic [1:0][15:0]                  key_q;
	logic [1:0][12:0]                  trip_level;
	logic [1:0]                        mon_on;
	logic [1:0][3:0]                   avg_win;
	logic [1:0]                        swap;
	logic [1:0]                        gain_en;
	logic [1:0]                        pdp_to_out;
	logic [1:0][7:0]                   irq_en;
	logic [1:0][7:0]                   irq_status;
	logic [1:0][12:0]                  pwr_readback;
	logic [1:0]                        pdp_trip;
	logic [1:0]                        tx_prot_prev;
	logic [1:0]                        irq_hit;
	dual_ctrl_pkg::align_state_e [1:0] state;
	logic [1:0]                        rsel_page;
	logic                              rsel;
	logic [7:0]                        next_rdata;

	// SYSREF pin synchroniser, edge found past the second stage
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sysref_s1 <= 1'b0;
			sysref_s2 <= 1'b0;
			sysref_s3 <= 1'b0;
		end else if (CLK_EN) begin
			sysref_s1 <= SYSREF;
			sysref_s2 <= sysref_s1;
			sysref_s3 <= sysref_s2;
		end
	end
	assign sysref_rise = sysref_s2 && !sysref_s3;

	// dual page select: bit0 dual A, bit1 dual B
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			page <= dual_ctrl_pkg::PAGE_RESET;
		end else if (CLK_EN && REG_WR && REG_ADDR == dual_ctrl_pkg::ADDR_PAGE) begin
			page <= REG_WDATA[1:0];
		end
	end

	genvar d;
	generate
		for (d = 0; d < 2; d++) begin : g_dual
			logic wr;
			logic event_hit;
			logic key_seen;
			logic done;
			logic [11:0] en_addr;
			logic [11:0] st_addr;

			assign wr       = CLK_EN && REG_WR && page[d];
			assign en_addr  = dual_ctrl_pkg::ADDR_IRQ_EN_A + 12'(d);
			assign st_addr  = dual_ctrl_pkg::ADDR_IRQ_ST_A + 12'(d);
			assign key_seen = DIN_I[d] == key_i[d] && DIN_Q[d] == key_q[d];
			assign event_hit = (mode[d] == dual_ctrl_pkg::MODE_SYSREF) ?
				(SUBCLASS1 ? (sysref_rise && LMFC_ALIGN_REQ) : LMFC_ALIGN_REQ) :
				key_seen;
			assign done = state[d] == dual_ctrl_pkg::ALIGN_CHECK;

			// paged configuration registers
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					key_i[d]      <= 16'h0000;
					key_q[d]      <= 16'h0000;
					trip_level[d] <= 13'h0000;
					mon_on[d]     <= 1'b0;
					avg_win[d]    <= 4'h0;
					swap[d]       <= 1'b0;
					gain_en[d]    <= dual_ctrl_pkg::GAIN_EN_RESET;
					pdp_to_out[d] <= 1'b0;
				end else if (wr) begin
					if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_I0) begin
						key_i[d][7:0] <= REG_WDATA;
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_I1) begin
						key_i[d][15:8] <= REG_WDATA;
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_Q0) begin
						key_q[d][7:0] <= REG_WDATA;
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_Q1) begin
						key_q[d][15:8] <= REG_WDATA;
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_TRIP_LO) begin
						trip_level[d][7:0] <= REG_WDATA;
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_TRIP_HI) begin
						trip_level[d][12:8] <= REG_WDATA[4:0];
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_MON_CFG) begin
						mon_on[d]  <= REG_WDATA[dual_ctrl_pkg::BIT_MON_ON];
						avg_win[d] <= REG_WDATA[3:0];
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_ROUTE) begin
						swap[d]    <= REG_WDATA[dual_ctrl_pkg::BIT_SWAP];
						gain_en[d] <= REG_WDATA[dual_ctrl_pkg::BIT_GAIN_EN];
					end else if (REG_ADDR == dual_ctrl_pkg::ADDR_PROT_SEL) begin
						pdp_to_out[d] <= REG_WDATA[dual_ctrl_pkg::BIT_PDP_OUT];
					end
				end
			end

			// alignment control: mode, arm, result flags
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					mode[d]       <= 2'h0;
					arm[d]        <= 1'b0;
					match_flag[d] <= 1'b0;
					pass_flag[d]  <= 1'b0;
					fail_flag[d]  <= 1'b0;
				end else if (CLK_EN) begin
					if (wr && REG_ADDR == dual_ctrl_pkg::ADDR_ALIGN_CTRL) begin
						mode[d] <= REG_WDATA[1:0];
						arm[d]  <= REG_WDATA[dual_ctrl_pkg::BIT_ARM];
						if (REG_WDATA[dual_ctrl_pkg::BIT_ARM]) begin
							match_flag[d] <= 1'b0;
							pass_flag[d]  <= 1'b0;
							fail_flag[d]  <= 1'b0;
						end
					end
					if (done) begin
						arm[d] <= 1'b0;
					end
					if (state[d] == dual_ctrl_pkg::ALIGN_WAIT && mode[d] == dual_ctrl_pkg::MODE_KEY
						&& key_seen) begin
						match_flag[d] <= 1'b1;
					end
					if (done && NCO_PHASE_ZERO[d]) begin
						pass_flag[d] <= 1'b1;
					end
					if (done && !NCO_PHASE_ZERO[d]) begin
						fail_flag[d] <= 1'b1;
					end
				end
			end

			// alignment sequencer; oscillator answers the cycle after the clear
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					state[d]     <= dual_ctrl_pkg::ALIGN_IDLE;
					NCO_CLEAR[d] <= 1'b0;
				end else if (CLK_EN) begin
					NCO_CLEAR[d] <= 1'b0;
					case (state[d])
						dual_ctrl_pkg::ALIGN_IDLE: begin
							if (arm[d] && (mode[d] == dual_ctrl_pkg::MODE_SYSREF ||
								mode[d] == dual_ctrl_pkg::MODE_KEY)) begin
								state[d] <= dual_ctrl_pkg::ALIGN_WAIT;
							end
						end
						dual_ctrl_pkg::ALIGN_WAIT: begin
							if (!arm[d]) begin
								state[d] <= dual_ctrl_pkg::ALIGN_IDLE;
							end else if (event_hit) begin
								state[d]     <= dual_ctrl_pkg::ALIGN_CLEAR;
								NCO_CLEAR[d] <= 1'b1;
							end
						end
						dual_ctrl_pkg::ALIGN_CLEAR: begin
							state[d] <= dual_ctrl_pkg::ALIGN_CHECK;
						end
						default: begin
							state[d] <= dual_ctrl_pkg::ALIGN_IDLE;
						end
					endcase
				end
			end

			// event enables and sticky status, set beats clear
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					irq_en[d]     <= dual_ctrl_pkg::REG_RESET;
					irq_status[d] <= dual_ctrl_pkg::REG_RESET;
				end else if (CLK_EN) begin
					if (REG_WR && REG_ADDR == en_addr) begin
						irq_en[d] <= REG_WDATA;
					end
					if (REG_WR && REG_ADDR == st_addr) begin
						irq_status[d] <= irq_status[d] & ~REG_WDATA;
					end
					if (done) begin
						irq_status[d][dual_ctrl_pkg::BIT_IRQ_ALIGN] <= 1'b1;
					end
					if (pdp_trip[d] && !OVERPOWER_TRIP[d]) begin
						irq_status[d][dual_ctrl_pkg::BIT_IRQ_TRIP] <= 1'b1;
					end
				end
			end
			assign irq_hit[d] =
				(irq_status[d][dual_ctrl_pkg::BIT_IRQ_ALIGN] && irq_en[d][dual_ctrl_pkg::BIT_IRQ_ALIGN]) ||
				(irq_status[d][dual_ctrl_pkg::BIT_IRQ_TRIP] && irq_en[d][dual_ctrl_pkg::BIT_IRQ_TRIP]);

			// output routing, protection pin, ramp trigger
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					DAC_I[d]          <= 16'h0000;
					DAC_Q[d]          <= 16'h0000;
					OVERPOWER_TRIP[d] <= 1'b0;
					PROTECT_OUT[d]    <= 1'b0;
					RAMP_START[d]     <= 1'b0;
					tx_prot_prev[d]   <= 1'b0;
				end else if (CLK_EN) begin
					DAC_I[d]          <= DP_I[d];
					DAC_Q[d]          <= swap[d] ? DP_I[d] : DP_Q[d];
					OVERPOWER_TRIP[d] <= pdp_trip[d];
					PROTECT_OUT[d]    <= pdp_to_out[d] && pdp_trip[d];
					tx_prot_prev[d]   <= TX_PROTECT[d];
					RAMP_START[d]     <= gain_en[d] &&
						((TX_PROTECT[d] != tx_prot_prev[d]) || LMFC_ROTATE);
				end
			end

			power_detect_protect u_pdp (
				.clk        (SYS_CLK),
				.rst        (RST),
				.ce         (CLK_EN),
				.mon_on     (mon_on[d]),
				.avg_win    (avg_win[d]),
				.trip_level (trip_level[d]),
				.din_i      (DIN_I[d]),
				.din_q      (DIN_Q[d]),
				.trip       (pdp_trip[d]),
				.readback   (pwr_readback[d])
			);

			swap_route_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				swap[d] |=> DAC_Q[d] == $past(DP_I[d]))
				else $error("swap did not route in-phase to Q");
			clear_result_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				NCO_CLEAR[d] |-> ##2 (pass_flag[d] != fail_flag[d]) && !arm[d])
				else $error("no single result after clear");
			arm_selfclear_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				(done && !(REG_WR && page[d] && REG_ADDR == dual_ctrl_pkg::ADDR_ALIGN_CTRL))
				|=> !arm[d])
				else $error("arm kept after attempt");
			key_match_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				(state[d] == dual_ctrl_pkg::ALIGN_WAIT && arm[d] &&
				mode[d] == dual_ctrl_pkg::MODE_KEY && key_seen) |=> match_flag[d])
				else $error("key match not flagged");
			sysref_wait_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				(state[d] == dual_ctrl_pkg::ALIGN_WAIT && arm[d] && SUBCLASS1 &&
				mode[d] == dual_ctrl_pkg::MODE_SYSREF && !sysref_rise) |=> !NCO_CLEAR[d])
				else $error("alignment without SYSREF edge");
			status_sticky_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				(irq_status[d][dual_ctrl_pkg::BIT_IRQ_TRIP] && !(REG_WR && REG_ADDR == st_addr))
				|=> irq_status[d][dual_ctrl_pkg::BIT_IRQ_TRIP])
				else $error("trip status dropped without clear");
			protect_pin_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				PROTECT_OUT[d] |-> $past(pdp_trip[d]) && $past(pdp_to_out[d]))
				else $error("protect pin without enabled trip");
			ramp_gain_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
				RAMP_START[d] |-> $past(gain_en[d]))
				else $error("ramp started with gain off");
		end
	endgenerate

	// reads come from dual A when its page bit is set, else dual B
	assign rsel_page = page;
	assign rsel      = !rsel_page[0];

	always_comb begin
		next_rdata = 8'h00;
		if (REG_ADDR == dual_ctrl_pkg::ADDR_PAGE) begin
			next_rdata = {6'h00, page};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_IRQ_EN_A) begin
			next_rdata = irq_en[0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_IRQ_EN_A + 12'h001) begin
			next_rdata = irq_en[1];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_IRQ_ST_A) begin
			next_rdata = irq_status[0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_IRQ_ST_A + 12'h001) begin
			next_rdata = irq_status[1];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_ALIGN_CTRL) begin
			next_rdata = {arm[rsel], 1'b0, match_flag[rsel], pass_flag[rsel], fail_flag[rsel],
				1'b0, mode[rsel]};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_I0) begin
			next_rdata = key_i[rsel][7:0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_I1) begin
			next_rdata = key_i[rsel][15:8];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_Q0) begin
			next_rdata = key_q[rsel][7:0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_KEY_Q1) begin
			next_rdata = key_q[rsel][15:8];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_TRIP_LO) begin
			next_rdata = trip_level[rsel][7:0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_TRIP_HI) begin
			next_rdata = {3'h0, trip_level[rsel][12:8]};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_MON_CFG) begin
			next_rdata = {mon_on[rsel], 3'h0, avg_win[rsel]};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_PWR_LO) begin
			next_rdata = pwr_readback[rsel][7:0];
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_PWR_HI) begin
			next_rdata = {3'h0, pwr_readback[rsel][12:8]};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_ROUTE) begin
			next_rdata = {2'h0, gain_en[rsel], 4'h0, swap[rsel]};
		end else if (REG_ADDR == dual_ctrl_pkg::ADDR_PROT_SEL) begin
			next_rdata = {1'b0, pdp_to_out[rsel], 6'h00};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
			IRQ       <= 1'b0;
		end else if (CLK_EN) begin
			if (REG_RD) begin
				REG_RDATA <= next_rdata;
			end
			IRQ <= |irq_hit;
		end
	end

	irq_enabled_a: assert property (@(posedge SYS_CLK) disable iff (RST || !CLK_EN)
		(irq_en[0] == 8'h00 && irq_en[1] == 8'h00) |=> !IRQ)
		else $error("irq raised with all events masked");
endmodule // dual_nco_align_power_protect
`default_nettype wire

// [verilog/dual_ctrl_pkg.sv]
// constants and types shared by the dual control logic
`default_nettype none
package dual_ctrl_pkg;
	// register offsets
	localparam logic [11:0] ADDR_PAGE       = 12'h008;
	localparam logic [11:0] ADDR_PROT_SEL   = 12'h013;
	localparam logic [11:0] ADDR_IRQ_EN_A   = 12'h021;
	localparam logic [11:0] ADDR_IRQ_ST_A   = 12'h025;
	localparam logic [11:0] ADDR_ALIGN_CTRL = 12'h050;
	localparam logic [11:0] ADDR_KEY_I0     = 12'h051;
	localparam logic [11:0] ADDR_KEY_I1     = 12'h052;
	localparam logic [11:0] ADDR_KEY_Q0     = 12'h053;
	localparam logic [11:0] ADDR_KEY_Q1     = 12'h054;
	localparam logic [11:0] ADDR_TRIP_LO    = 12'h060;
	localparam logic [11:0] ADDR_TRIP_HI    = 12'h061;
	localparam logic [11:0] ADDR_MON_CFG    = 12'h062;
	localparam logic [11:0] ADDR_PWR_LO     = 12'h063;
	localparam logic [11:0] ADDR_PWR_HI     = 12'h064;
	localparam logic [11:0] ADDR_ROUTE      = 12'h111;
	// field positions
	localparam int BIT_ARM       = 7;
	localparam int BIT_MATCH     = 5;
	localparam int BIT_PASS      = 4;
	localparam int BIT_FAIL      = 3;
	localparam int BIT_MON_ON    = 7;
	localparam int BIT_SWAP      = 0;
	localparam int BIT_GAIN_EN   = 5;
	localparam int BIT_PDP_OUT   = 6;
	localparam int BIT_IRQ_ALIGN = 4;
	localparam int BIT_IRQ_TRIP  = 7;
	// field values
	localparam logic [1:0] MODE_SYSREF = 2'h1;
	localparam logic [1:0] MODE_KEY    = 2'h2;
	localparam logic [3:0] AVG_MAX     = 4'ha;
	localparam logic [4:0] AVG_BASE    = 5'h09;
	localparam int         PWR_SAMPLE_MSBS = 7;
	// reset values
	localparam logic [1:0] PAGE_RESET    = 2'h3;
	localparam logic       GAIN_EN_RESET = 1'b1;
	localparam logic [7:0] REG_RESET     = 8'h00;
	// alignment sequencer, gray coded along its path
	typedef enum logic [1:0] {
		ALIGN_IDLE  = 2'b00,
		ALIGN_WAIT  = 2'b01,
		ALIGN_CLEAR = 2'b11,
		ALIGN_CHECK = 2'b10
	} align_state_e;
endpackage
`default_nettype wire

// [verilog/power_detect_protect.sv]
// per-dual power detector: i^2+q^2 average, threshold trip, peak readback
`timescale 1ns/1ps
`default_nettype none
module power_detect_protect (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// configuration
	input  wire logic        mon_on,
	input  wire logic [3:0]  avg_win,
	input  wire logic [12:0] trip_level,
	// samples at the converter input
	input  wire logic [15:0] din_i,
	input  wire logic [15:0] din_q,
	// results
	output logic             trip,
	output logic [12:0]      readback
);
	logic signed [6:0]  top_i;
	logic signed [6:0]  top_q;
	logic signed [13:0] sq_i;
	logic signed [13:0] sq_q;
	logic [13:0]        sample_pwr;
	logic [3:0]         eff_win;
	logic [4:0]         shamt;
	logic [18:0]        last_cnt;
	logic [18:0]        cnt;
	logic [32:0]        acc;
	logic [32:0]        avg_sum;
	logic [32:0]        shifted;
	logic [12:0]        next_avg;
	logic [12:0]        avg_pwr;
	logic [12:0]        peak;
	logic               crossed;

	// short tap straight off the input, seven msbs only
	assign top_i      = din_i[15:16-dual_ctrl_pkg::PWR_SAMPLE_MSBS];
	assign top_q      = din_q[15:16-dual_ctrl_pkg::PWR_SAMPLE_MSBS];
	assign sq_i       = top_i * top_i;
	assign sq_q       = top_q * top_q;
	assign eff_win    = (avg_win > dual_ctrl_pkg::AVG_MAX) ? dual_ctrl_pkg::AVG_MAX : avg_win;
	assign shamt      = dual_ctrl_pkg::AVG_BASE + {1'b0, eff_win};
	assign last_cnt   = 19'((20'h1 << shamt) - 20'h1);
	assign avg_sum    = acc + {19'h0, sample_pwr};
	assign shifted    = avg_sum >> shamt;
	assign next_avg   = (|shifted[32:13]) ? 13'h1fff : shifted[12:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			sample_pwr <= 14'h0;
		end else if (ce) begin
			sample_pwr <= $unsigned(sq_i) + $unsigned(sq_q);
		end
	end

	// window accumulator
	always_ff @(posedge clk) begin
		if (rst || (ce && !mon_on)) begin
			cnt     <= 19'h0;
			acc     <= 33'h0;
			avg_pwr <= 13'h0;
		end else if (ce) begin
			if (cnt >= last_cnt) begin
				cnt     <= 19'h0;
				acc     <= 33'h0;
				avg_pwr <= next_avg;
			end else begin
				cnt <= cnt + 19'h1;
				acc <= avg_sum;
			end
		end
	end

	// trip, peak capture and readback
	always_ff @(posedge clk) begin
		if (rst || (ce && !mon_on)) begin
			trip     <= 1'b0;
			crossed  <= 1'b0;
			peak     <= 13'h0;
			readback <= 13'h0;
		end else if (ce) begin
			trip <= avg_pwr > trip_level;
			if (avg_pwr > trip_level) begin
				crossed <= 1'b1;
			end
			if (avg_pwr > peak) begin
				peak <= avg_pwr;
			end
			readback <= (crossed || avg_pwr > trip_level) ?
				((avg_pwr > peak) ? avg_pwr : peak) : avg_pwr;
		end
	end

	trip_level_a: assert property (@(posedge clk) disable iff (rst || !ce)
		(mon_on && avg_pwr > trip_level) |=> trip)
		else $error("trip missing above threshold");
	trip_off_a: assert property (@(posedge clk) disable iff (rst || !ce)
		!mon_on |=> !trip)
		else $error("trip while monitor off");
	peak_hold_a: assert property (@(posedge clk) disable iff (rst || !ce)
		(mon_on && crossed && avg_pwr <= peak && $stable(peak) && $stable(mon_on))
		|=> readback == $past(peak))
		else $error("readback not peak after crossing");
endmodule // power_detect_protect
`default_nettype wire

// [tb/nco_far_side.sv]
// far-side model: sample source and oscillator phase report
`timescale 1ns/1ps
`default_nettype none
module nco_far_side (
	// clock
	input  wire logic             clk,
	// sample source
	input  wire logic             send,
	input  wire logic [15:0]      fill,
	input  wire logic [15:0]      key_i,
	input  wire logic [15:0]      key_q,
	output logic      [1:0][15:0] din_i,
	output logic      [1:0][15:0] din_q,
	// oscillator side
	input  wire logic             ok,
	input  wire logic [1:0]       nco_clear,
	output logic      [1:0]       phase_zero
);
	// same key to both duals in one cycle
	assign din_i = send ? {key_i, key_i} : {fill, fill};
	assign din_q = send ? {key_q, key_q} : {fill, fill};
	// phase reported cleared one cycle after the pulse unless told to fail
	always_ff @(posedge clk) begin
		phase_zero <= ok ? nco_clear : 2'b00;
	end
endmodule // nco_far_side
`default_nettype wire

// [tb/dual_nco_align_power_protect_bench.sv]
// bench for dual routing, oscillator alignment and power trip
`timescale 1ns/1ps
`default_nettype none
module dual_nco_align_power_protect_bench;
	logic             sys_clk = 1'b0;
	logic             rst = 1'b1;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic [11:0]      reg_addr = 12'h000;
	logic [7:0]       reg_wdata = 8'h00;
	logic [7:0]       reg_rdata;
	logic             lmfc_req = 1'b0;
	logic             send = 1'b0;
	logic             ok = 1'b1;
	logic [15:0]      fill = 16'h0000;
	logic [15:0]      key_i = 16'h5a3c;
	logic [15:0]      key_q = 16'hc3a5;
	logic [1:0][15:0] dp_i = '0;
	logic [1:0][15:0] dp_q = '0;
	logic [1:0][15:0] din_i, din_q, dac_i, dac_q;
	logic [1:0]       phase_zero, nco_clear, trip, prot_out, ramp;
	logic [1:0]       tx_prot = 2'b00;
	logic             clk_en = 1'b1;
	logic             sysref = 1'b0;
	logic             subclass1 = 1'b0;
	logic             irq;
	int               err_count = 0;
	int               num_checks = 0;
	int               cycles = 0;

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	dual_nco_align_power_protect i_dual_nco_align_power_protect (
		.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(clk_en),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.SYSREF(sysref), .SUBCLASS1(subclass1), .LMFC_ALIGN_REQ(lmfc_req),
		.LMFC_ROTATE(1'b0), .NCO_PHASE_ZERO(phase_zero), .NCO_CLEAR(nco_clear),
		.DIN_I(din_i), .DIN_Q(din_q), .DP_I(dp_i), .DP_Q(dp_q),
		.DAC_I(dac_i), .DAC_Q(dac_q), .TX_PROTECT(tx_prot),
		.OVERPOWER_TRIP(trip), .PROTECT_OUT(prot_out), .RAMP_START(ramp), .IRQ(irq));
	nco_far_side i_nco_far_side (
		.clk(sys_clk), .send(send), .fill(fill), .key_i(key_i), .key_q(key_q),
		.din_i(din_i), .din_q(din_q), .ok(ok), .nco_clear(nco_clear),
		.phase_zero(phase_zero));

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		check(name, {8'h00, reg_rdata}, {8'h00, exp});
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task t_reset;
		rd(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h00, "align ctrl");
		rd(dual_ctrl_pkg::ADDR_ROUTE, 8'h20, "route reg");
		rd(12'h0ff, 8'h00, "unmapped");
		$display("reset test done");
	endtask
	task t_swap;
		wr(dual_ctrl_pkg::ADDR_ROUTE, 8'h21);
		dp_i = {16'h1111, 16'h1234};
		dp_q = {16'h2222, 16'h5678};
		repeat (2) @(negedge sys_clk);
		check("dac_q a", dac_q[0], 16'h1234);
		check("dac_q b", dac_q[1], 16'h1111);
		check("dac_i a", dac_i[0], 16'h1234);
		clk_en = 1'b0;
		dp_i = {16'h1111, 16'h4321};
		@(negedge sys_clk);
		check("dac_q frozen", dac_q[0], 16'h1234);
		clk_en = 1'b1;
		wr(dual_ctrl_pkg::ADDR_ROUTE, 8'h20);
		@(negedge sys_clk);
		check("dac_q plain", dac_q[0], 16'h5678);
		$display("swap test done");
	endtask
	task t_ramp;
		@(negedge sys_clk);
		tx_prot = 2'b11;
		@(negedge sys_clk);
		check("ramp edge", {14'h0000, ramp}, 16'h0003);
		@(negedge sys_clk);
		check("ramp pulse", {14'h0000, ramp}, 16'h0000);
		wr(dual_ctrl_pkg::ADDR_ROUTE, 8'h00);
		tx_prot = 2'b00;
		@(negedge sys_clk);
		check("ramp gain off", {14'h0000, ramp}, 16'h0000);
		wr(dual_ctrl_pkg::ADDR_ROUTE, 8'h20);
		$display("ramp test done");
	endtask
	task t_key;
		wr(dual_ctrl_pkg::ADDR_KEY_I0, key_i[7:0]);
		wr(dual_ctrl_pkg::ADDR_KEY_I1, key_i[15:8]);
		wr(dual_ctrl_pkg::ADDR_KEY_Q0, key_q[7:0]);
		wr(dual_ctrl_pkg::ADDR_KEY_Q1, key_q[15:8]);
		wr(dual_ctrl_pkg::ADDR_IRQ_EN_A, 8'h10);
		wr(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h82);
		send = 1'b1;
		repeat (3) @(negedge sys_clk);
		send = 1'b0;
		repeat (4) @(negedge sys_clk);
		rd(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h32, "key align");
		check("irq align", {15'h0000, irq}, 16'h0001);
		rd(dual_ctrl_pkg::ADDR_IRQ_ST_A, 8'h10, "status align");
		wr(dual_ctrl_pkg::ADDR_IRQ_ST_A, 8'h10);
		rd(dual_ctrl_pkg::ADDR_IRQ_ST_A, 8'h00, "status cleared");
		check("irq cleared", {15'h0000, irq}, 16'h0000);
		$display("key test done");
	endtask
	task t_sysref_fail;
		ok = 1'b0;
		wr(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h81);
		lmfc_req = 1'b1;
		repeat (2) @(negedge sys_clk);
		lmfc_req = 1'b0;
		repeat (4) @(negedge sys_clk);
		rd(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h09, "sysref fail");
		ok = 1'b1;
		$display("sysref test done");
	endtask
	task t_sysref_edge;
		subclass1 = 1'b1;
		wr(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h81);
		lmfc_req = 1'b1;
		repeat (4) @(negedge sys_clk);
		rd(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h81, "waits for edge");
		sysref = 1'b1;
		repeat (6) @(negedge sys_clk);
		sysref = 1'b0;
		lmfc_req = 1'b0;
		rd(dual_ctrl_pkg::ADDR_ALIGN_CTRL, 8'h11, "sysref pass");
		subclass1 = 1'b0;
		$display("sysref edge test done");
	endtask
	task t_power;
		wr(dual_ctrl_pkg::ADDR_TRIP_LO, 8'h02);
		wr(dual_ctrl_pkg::ADDR_TRIP_HI, 8'h1f);
		wr(dual_ctrl_pkg::ADDR_PROT_SEL, 8'h40);
		wr(dual_ctrl_pkg::ADDR_IRQ_EN_A, 8'h80);
		fill = 16'h7fff;
		wr(dual_ctrl_pkg::ADDR_MON_CFG, 8'h80);
		repeat (1200) @(negedge sys_clk);
		check("no trip at level", {14'h0000, trip}, 16'h0000);
		rd(dual_ctrl_pkg::ADDR_PWR_LO, 8'h02, "power lo");
		wr(dual_ctrl_pkg::ADDR_TRIP_LO, 8'h01);
		for (int i = 0; i < 1200 && trip[0] !== 1'b1; i++)
			@(negedge sys_clk);
		check("trip", {14'h0000, trip}, 16'h0003);
		check("protect out", {14'h0000, prot_out}, 16'h0003);
		wr(dual_ctrl_pkg::ADDR_TRIP_HI, 8'h00);
		fill = 16'h3fff;
		repeat (600) @(negedge sys_clk);
		check("trip held", {14'h0000, trip}, 16'h0003);
		check("irq trip", {15'h0000, irq}, 16'h0001);
		rd(dual_ctrl_pkg::ADDR_PWR_LO, 8'h02, "peak lo");
		rd(dual_ctrl_pkg::ADDR_PWR_HI, 8'h1f, "peak hi");
		wr(dual_ctrl_pkg::ADDR_MON_CFG, 8'h00);
		repeat (3) @(negedge sys_clk);
		check("monitor off", {14'h0000, trip}, 16'h0000);
		$display("power test done");
	endtask

	initial begin
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_swap();
		t_ramp();
		t_key();
		t_sysref_fail();
		t_sysref_edge();
		t_power();
		results();
	end
endmodule // dual_nco_align_power_protect_bench
`default_nettype wire
